// >>> shared/ocd_defines.svh
// Register offsets, field positions, reset values and timing counts of the clock control block
`ifndef OCD_DEFINES_SVH
`define OCD_DEFINES_SVH
// Byte addresses on the register bus
`define OCD_ADDR_OSC_CTRL   4'h0
`define OCD_ADDR_CLK_DIV    4'h4
`define OCD_ADDR_UNLOCK     4'h8
`define OCD_ADDR_IRQ_STAT   4'hC
// Unlock keys, written in this order to the unlock register
`define OCD_KEY1            16'h0057
`define OCD_KEY2            16'h00AA
// Oscillator control fields
`define OCD_OC_SWREQ        0
`define OCD_OC_FAIL         3
`define OCD_OC_NEW_OSC_SELECT_LO      8
`define OCD_OC_COSC_LO      12
// Clock divisor fields
`define OCD_CD_PRE_LO       0
`define OCD_CD_CPU_SLOW_RATIO_LO      12
`define OCD_CD_SLOW_RATIO_APPLY        11
`define OCD_CD_ROI          15
// Interrupt status and mask bits (mask at bit + 8)
`define OCD_IRQ_FAIL        0
`define OCD_IRQ_SWDONE      1
`define OCD_IRQ_MASK_LO     8
// Reset values
`define OCD_OSC_RESET       3'h0
`define OCD_PRE_RESET       5'h00
`define OCD_CPU_SLOW_RATIO_RESET      3'h0
`define OCD_CPU_SLOW_RATIO_RATIO_OFF  3'h0
// Oscillator codes
`define OCD_OSC_FRC         3'h0
`define OCD_OSC_INTERNAL_RC_WITH_PLL      3'h1
`define OCD_OSC_PRIPLL      3'h3
// Clock switch settle time in ns, and its cycle count at 40 MHz
`define OCD_SW_SETTLE_NS    200
`define OCD_CLK_PERIOD_NS   25
`define OCD_SW_CYCLES       ((`OCD_SW_SETTLE_NS + `OCD_CLK_PERIOD_NS - 1) / `OCD_CLK_PERIOD_NS)
`endif

// >>> shared/ocd_pkg.sv
// Types of the clock control block
`default_nettype none
package ocd_pkg;
    typedef enum logic [1:0] {OCD_LK_IDLE, OCD_LK_KEY1, OCD_LK_OPEN} ocd_lock_t;
    typedef enum logic {OCD_SW_IDLE, OCD_SW_BUSY} ocd_sw_t;
endpackage
`default_nettype wire

// >>> rtl/ocd_switch_timer.sv
// Settle timer for an oscillator switch
`include "ocd_defines.svh"
`default_nettype none
module ocd_switch_timer
    import ocd_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic start, // Begin a switch
    output logic done // One-cycle pulse when switch completes
);
    localparam int CYC = `OCD_SW_CYCLES;
    ocd_sw_t state_r;
    logic [7:0] cnt_r;
    wire last = (cnt_r == 8'(CYC - 1));
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_r <= OCD_SW_IDLE;
            cnt_r <= 8'h00;
        end
        else
        begin
            unique case (state_r)
                OCD_SW_IDLE:
                begin
                    cnt_r <= 8'h00;
                    if (start)
                        state_r <= OCD_SW_BUSY;
                end
                OCD_SW_BUSY:
                begin
                    cnt_r <= cnt_r + 8'h01;
                    if (last)
                        state_r <= OCD_SW_IDLE;
                end
            endcase
        end
    end
    assign done = (state_r == OCD_SW_BUSY) && last;
endmodule // ocd_switch_timer
`default_nettype wire

// >>> rtl/ocd_clock_ctrl.sv
// Oscillator switch, fail flag and divider control with AXI4-Lite registers
//
// Summary of operation
// - Monitor failure sets clock fail flag
// - Switch request starts switch, clears when done
// - Control register writes need unlock first
// - Software one on fail flag acts as failure
// - Prescaler divides by field plus two
// - Ratio writes ignored while apply bit set
// - Apply bit cannot set when ratio zero
// - Interrupt with recover bit clears apply bit
// - Unused control bits read as zero
//
// Register map, byte addresses, data in bits 15:0
// 0x0 oscillator control
//     bit 0 switch request, reads 1 until the switch completes
//     bit 3 clock fail flag, software one acts as a failure
//     bits 10:8 new oscillator, frozen while a switch runs
//     bits 14:12 current oscillator, follows bits 10:8 at completion
//     all other bits read 0
//     writes taken only right after the unlock pair
// 0x4 clock divisor
//     bits 4:0 prescaler, output factor is field plus two
//     bit 11 apply ratio, bits 14:12 ratio, bit 15 recover
//     ratio frozen while apply is set
// 0x8 unlock, write only: first key then second key
//     any write elsewhere closes the unlock again
// 0xC interrupt status bits 1:0, mask bits 9:8
//     status clears on read; an event in that cycle wins
//
// Limitation: source changes between PLL modes are not policed;
// software must route them through the plain RC oscillator
`include "ocd_defines.svh"
`default_nettype none
module ocd_clock_ctrl
    import ocd_pkg::*;
(
    input wire logic SYS_CLK, // 40 MHz system clock
    input wire logic RST_N, // Synchronous reset, active low
    input wire logic [3:0] S_AXI_AWADDR, // Write address
    input wire logic S_AXI_AWVALID, // Write address valid
    output logic S_AXI_AWREADY, // Write address ready
    input wire logic [31:0] S_AXI_WDATA, // Write data
    input wire logic [3:0] S_AXI_WSTRB, // Write strobes
    input wire logic S_AXI_WVALID, // Write data valid
    output logic S_AXI_WREADY, // Write data ready
    output logic [1:0] S_AXI_BRESP, // Write response
    output logic S_AXI_BVALID, // Write response valid
    input wire logic S_AXI_BREADY, // Write response ready
    input wire logic [3:0] S_AXI_ARADDR, // Read address
    input wire logic S_AXI_ARVALID, // Read address valid
    output logic S_AXI_ARREADY, // Read address ready
    output logic [31:0] S_AXI_RDATA, // Read data
    output logic [1:0] S_AXI_RRESP, // Read response
    output logic S_AXI_RVALID, // Read data valid
    input wire logic S_AXI_RREADY, // Read data ready
    input wire logic CLOCK_FAIL_DET, // Monitor failure detect, level
    input wire logic CPU_INT_EVENT, // Interrupt taken by the CPU, pulse
    output logic OSC_FAIL_TRAP, // Oscillator failure trap, pulse
    output logic [2:0] ACTIVE_OSC, // Oscillator in use
    output logic [5:0] PLL_PRESCALE_FACTOR, // Phase detector input divisor
    output logic [2:0] CPU_SLOW_RATIO, // CPU clock reduction ratio
    output logic SLOW_RATIO_ACTIVE, // Reduction ratio applied
    output logic IRQ // Interrupt, level
);
    // ==========================================================
    // Write channel capture
    logic aw_got_r, w_got_r, bvalid_r;
    logic [3:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    wire aw_hs = S_AXI_AWVALID && S_AXI_AWREADY;
    wire w_hs = S_AXI_WVALID && S_AXI_WREADY;
    // Address and data may arrive in either order; B follows both
    wire wr_go = aw_got_r && w_got_r && !bvalid_r;
    assign S_AXI_AWREADY = !aw_got_r && !bvalid_r;
    assign S_AXI_WREADY = !w_got_r && !bvalid_r;
    assign S_AXI_BVALID = bvalid_r;
    assign S_AXI_BRESP = 2'b00;
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            bvalid_r <= 1'b0;
            aw_addr_r <= 4'h0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end
        else
        begin
            if (aw_hs)
            begin
                aw_got_r <= 1'b1;
                aw_addr_r <= S_AXI_AWADDR;
            end
            if (w_hs)
            begin
                w_got_r <= 1'b1;
                w_data_r <= S_AXI_WDATA;
                w_strb_r <= S_AXI_WSTRB;
            end
            if (wr_go)
            begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                bvalid_r <= 1'b1;
            end
            else if (bvalid_r && S_AXI_BREADY)
                bvalid_r <= 1'b0;
        end
    end
    // ==========================================================
    // Write decode; registers hold 16 bits in the low two lanes
    wire wr_lo = wr_go && w_strb_r[0];
    wire wr_hi = wr_go && w_strb_r[1];
    wire sel_oc = (aw_addr_r == `OCD_ADDR_OSC_CTRL);
    wire sel_cd = (aw_addr_r == `OCD_ADDR_CLK_DIV);
    wire sel_ul = (aw_addr_r == `OCD_ADDR_UNLOCK);
    wire sel_is = (aw_addr_r == `OCD_ADDR_IRQ_STAT);
    wire [15:0] wd = w_data_r[15:0];
    // ==========================================================
    // Unlock sequence for the oscillator control register
    // A stray write between the keys drops back to idle
    ocd_lock_t lock_r;
    wire key1_wr = wr_lo && sel_ul && (wd == `OCD_KEY1);
    wire key2_wr = wr_lo && sel_ul && (wd == `OCD_KEY2);
    wire oc_wr = wr_go && sel_oc && (lock_r == OCD_LK_OPEN);
    wire oc_wr_lo = oc_wr && w_strb_r[0];
    wire oc_wr_hi = oc_wr && w_strb_r[1];
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
            lock_r <= OCD_LK_IDLE;
        else
        begin
            unique case (lock_r)
                OCD_LK_IDLE:
                    if (key1_wr)
                        lock_r <= OCD_LK_KEY1;
                OCD_LK_KEY1:
                    if (key2_wr)
                        lock_r <= OCD_LK_OPEN;
                    else if (wr_go)
                        lock_r <= OCD_LK_IDLE;
                OCD_LK_OPEN:
                    if (wr_go && !sel_ul)
                        lock_r <= OCD_LK_IDLE;
            endcase
        end
    end
    // ==========================================================
    // Oscillator control: switch request, new and current source
    logic [2:0] new_osc_select_r, cosc_r;
    logic swreq_r, fail_r;
    logic sw_done;
    wire sw_start = oc_wr_lo && wd[`OCD_OC_SWREQ] && !swreq_r;
    // Timer counts the settle time; done ends the request
    ocd_switch_timer u_timer (
        .clk(SYS_CLK),
        .rst_n(RST_N),
        .start(sw_start),
        .done(sw_done)
    );
    // Software one on the flag behaves as a detected failure
    wire fail_sw_set = oc_wr_lo && wd[`OCD_OC_FAIL];
    wire fail_sw_clr = oc_wr_lo && !wd[`OCD_OC_FAIL];
    // Hardware detect wins over a software clear in the same cycle
    wire fail_set = CLOCK_FAIL_DET || fail_sw_set;
    wire fail_nxt = fail_set || (fail_r && !fail_sw_clr);
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            new_osc_select_r <= `OCD_OSC_RESET;
            cosc_r <= `OCD_OSC_RESET;
            swreq_r <= 1'b0;
            fail_r <= 1'b0;
        end
        else
        begin
            if (oc_wr_hi && !swreq_r)
                new_osc_select_r <= wd[`OCD_OC_NEW_OSC_SELECT_LO +: 3];
            if (sw_start)
                swreq_r <= 1'b1;
            else if (sw_done)
            begin
                swreq_r <= 1'b0;
                cosc_r <= new_osc_select_r;
            end
            fail_r <= fail_nxt;
        end
    end
    // Trap in the cycle the flag rises
    assign OSC_FAIL_TRAP = !fail_r && fail_set;
    assign ACTIVE_OSC = cosc_r;
    wire [15:0] oc_rd = {1'b0, cosc_r, 1'b0, new_osc_select_r, 4'h0, fail_r, 2'b00, swreq_r};
    // ==========================================================
    // Clock divisor: prescaler, ratio, apply, recover
    logic [4:0] pre_r;
    logic [2:0] cpu_slow_ratio_r;
    logic slow_ratio_apply_r, roi_r;
    wire cd_lo = wr_lo && sel_cd;
    wire cd_hi = wr_hi && sel_cd;
    wire [2:0] cpu_slow_ratio_wd = wd[`OCD_CD_CPU_SLOW_RATIO_LO +: 3];
    wire cpu_slow_ratio_wr = cd_hi && !slow_ratio_apply_r;
    wire [2:0] cpu_slow_ratio_nxt = cpu_slow_ratio_wr ? cpu_slow_ratio_wd : cpu_slow_ratio_r;
    // Apply is judged against the ratio that results from this write
    wire slow_ratio_apply_req = cd_hi && wd[`OCD_CD_SLOW_RATIO_APPLY];
    wire slow_ratio_apply_ok = slow_ratio_apply_req && (cpu_slow_ratio_nxt != `OCD_CPU_SLOW_RATIO_RATIO_OFF);
    // Recover wins over a simultaneous software write of apply
    wire roi_clr = roi_r && CPU_INT_EVENT;
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            pre_r <= `OCD_PRE_RESET;
            cpu_slow_ratio_r <= `OCD_CPU_SLOW_RATIO_RESET;
            slow_ratio_apply_r <= 1'b0;
            roi_r <= 1'b0;
        end
        else
        begin
            if (cd_lo)
                pre_r <= wd[`OCD_CD_PRE_LO +: 5];
            cpu_slow_ratio_r <= cpu_slow_ratio_nxt;
            if (cd_hi)
                roi_r <= wd[`OCD_CD_ROI];
            if (roi_clr)
                slow_ratio_apply_r <= 1'b0;
            else if (cd_hi)
                slow_ratio_apply_r <= slow_ratio_apply_ok;
        end
    end
    assign PLL_PRESCALE_FACTOR = {1'b0, pre_r} + 6'd2;
    assign CPU_SLOW_RATIO = cpu_slow_ratio_r;
    assign SLOW_RATIO_ACTIVE = slow_ratio_apply_r;
    wire [15:0] cd_rd = {roi_r, cpu_slow_ratio_r, slow_ratio_apply_r, 6'h00, pre_r};
    // ==========================================================
    // Interrupt status, cleared by a read; a new event wins
    logic [1:0] ist_r, imask_r;
    // Switch done and fail trap are the two events
    wire [1:0] ev = {sw_done, OSC_FAIL_TRAP};
    wire rd_ist = S_AXI_ARVALID && S_AXI_ARREADY && (S_AXI_ARADDR == `OCD_ADDR_IRQ_STAT);
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            ist_r <= 2'b00;
            imask_r <= 2'b00;
        end
        else
        begin
            ist_r <= ev | (rd_ist ? 2'b00 : ist_r);
            if (wr_hi && sel_is)
                imask_r <= wd[`OCD_IRQ_MASK_LO +: 2];
        end
    end
    // Level output, high while any unmasked status bit is set
    assign IRQ = |(ist_r & imask_r);
    wire [15:0] is_rd = {6'h00, imask_r, 6'h00, ist_r};
    // ==========================================================
    // Read channel
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;
    wire ar_hs = S_AXI_ARVALID && S_AXI_ARREADY;
    wire rd_oc = (S_AXI_ARADDR == `OCD_ADDR_OSC_CTRL);
    wire rd_cd = (S_AXI_ARADDR == `OCD_ADDR_CLK_DIV);
    // Unlock reads as zero, it holds no readable state
    wire rd_ul = (S_AXI_ARADDR == `OCD_ADDR_UNLOCK);
    wire rd_is = (S_AXI_ARADDR == `OCD_ADDR_IRQ_STAT);
    wire rd_hit = rd_oc || rd_cd || rd_ul || rd_is;
    // Unmapped offsets answer SLVERR with zero data
    wire [15:0] rd_mux = rd_oc ? oc_rd :
        rd_cd ? cd_rd :
        rd_is ? is_rd :
        16'h0000;
    assign S_AXI_ARREADY = !rvalid_r;
    assign S_AXI_RVALID = rvalid_r;
    assign S_AXI_RDATA = rdata_r;
    assign S_AXI_RRESP = rresp_r;
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_N)
        begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= 2'b00;
        end
        else if (ar_hs)
        begin
            rvalid_r <= 1'b1;
            rdata_r <= {16'h0000, rd_mux};
            rresp_r <= rd_hit ? 2'b00 : 2'b10;
        end
        else if (rvalid_r && S_AXI_RREADY)
            rvalid_r <= 1'b0;
    end
endmodule // ocd_clock_ctrl
`default_nettype wire

// >>> testbench/ocd_clock_ctrl_assertions.sv
// Port checker for the clock control block
`default_nettype none
module ocd_clock_ctrl_checker (
    input wire logic SYS_CLK, // Clock
    input wire logic RST_N, // Reset
    input wire logic S_AXI_AWVALID, // Write address valid
    input wire logic S_AXI_AWREADY, // Write address ready
    input wire logic S_AXI_WVALID, // Write data valid
    input wire logic S_AXI_WREADY, // Write data ready
    input wire logic S_AXI_BVALID, // Response valid
    input wire logic S_AXI_BREADY, // Response ready
    input wire logic S_AXI_ARVALID, // Read address valid
    input wire logic S_AXI_ARREADY, // Read address ready
    input wire logic [31:0] S_AXI_RDATA, // Read data
    input wire logic S_AXI_RVALID, // Read valid
    input wire logic S_AXI_RREADY, // Read ready
    input wire logic OSC_FAIL_TRAP, // Trap
    input wire logic [5:0] PLL_PRESCALE_FACTOR, // Divisor
    input wire logic [2:0] CPU_SLOW_RATIO, // Ratio
    input wire logic SLOW_RATIO_ACTIVE // Ratio applied
);
    // ==========================
    // Properties
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    trap_pulse_a: assert property (OSC_FAIL_TRAP |=> !OSC_FAIL_TRAP)
        else $error("trap longer than one cycle");
    pre_range_a: assert property (PLL_PRESCALE_FACTOR inside {[2:33]})
        else $error("prescale factor out of range");
    apply_ratio_a: assert property (SLOW_RATIO_ACTIVE |-> CPU_SLOW_RATIO != 3'h0)
        else $error("ratio applied while zero");
    ratio_hold_a: assert property ($past(SLOW_RATIO_ACTIVE) |-> $stable(CPU_SLOW_RATIO))
        else $error("ratio changed while applied");
    bvalid_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
        else $error("write response dropped");
    rdata_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID
        && $stable(S_AXI_RDATA)) else $error("read data not held");
    read_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read not answered");
    write_answer_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
        && S_AXI_WREADY |-> ##2 S_AXI_BVALID) else $error("write not answered");
    trap_c: cover property (OSC_FAIL_TRAP);
    apply_c: cover property (SLOW_RATIO_ACTIVE);
    read_c: cover property (S_AXI_RVALID && S_AXI_RREADY);
endmodule // ocd_clock_ctrl_checker
bind ocd_clock_ctrl ocd_clock_ctrl_checker ocd_clock_ctrl_checker_i (.SYS_CLK, .RST_N,
    .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID,
    .S_AXI_BREADY, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RVALID,
    .S_AXI_RREADY, .OSC_FAIL_TRAP, .PLL_PRESCALE_FACTOR, .CPU_SLOW_RATIO,
    .SLOW_RATIO_ACTIVE);
`default_nettype wire

// >>> testbench/ocd_clock_ctrl_tb_top.sv
// Self-checking bench of the clock control block
`default_nettype none
module ocd_clock_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, rst_n, awvalid, wvalid, bready, arvalid, rready, fail_det, int_ev;
    logic [3:0] awaddr, araddr, wstrb;
    logic [31:0] wdata, rd;
    logic [1:0] rr;
    wire logic awready, wready, bvalid, arready, rvalid, trap, slow_act, irq;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [2:0] act_osc, slow_ratio;
    wire logic [5:0] pre;
    int num_errors, samples_checked, cyc, traps, t0;
    ocd_clock_ctrl ocd_clock_ctrl_i (.SYS_CLK(sys_clk), .RST_N(rst_n),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .CLOCK_FAIL_DET(fail_det),
        .CPU_INT_EVENT(int_ev), .OSC_FAIL_TRAP(trap), .ACTIVE_OSC(act_osc),
        .PLL_PRESCALE_FACTOR(pre), .CPU_SLOW_RATIO(slow_ratio),
        .SLOW_RATIO_ACTIVE(slow_act), .IRQ(irq));
    // ==========================
    // Clock, timeout, trap counter
    initial
    begin
        sys_clk = 0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            num_errors++;
            test_done();
        end
    end
    always @(negedge sys_clk)
        if (trap === 1'b1) traps++;
    // ==========================
    // Bus and compare tasks
    task chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        logic aw, w, b;
        @(posedge sys_clk);
        b = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (b !== 1'b1)
        begin
            @(negedge sys_clk);
            aw = awvalid & awready;
            w = wvalid & wready;
            b = bvalid & bready;
            @(posedge sys_clk);
            if (aw) awvalid <= 0;
            if (w) wvalid <= 0;
            if (b) bready <= 0;
        end
        chk("bresp", 32'h0000_0000, 32'(bresp));
    endtask
    task rc(input logic [3:0] a, input logic [31:0] e, input string n);
        logic h, b;
        @(posedge sys_clk);
        b = 0;
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        while (b !== 1'b1)
        begin
            @(negedge sys_clk);
            h = arvalid & arready;
            b = rvalid & rready;
            if (b)
            begin
                rd = rdata;
                rr = rresp;
            end
            @(posedge sys_clk);
            if (h) arvalid <= 0;
            if (b) rready <= 0;
        end
        chk(n, e, rd);
    endtask
    task unlock;
        wr(4'h8, 32'h0000_0057);
        wr(4'h8, 32'h0000_00AA);
    endtask
    // ==========================
    // Scenarios
    task t_reset;
        rc(4'h0, 32'h0000_0000, "osc_ctrl");
        rc(4'h4, 32'h0000_0000, "divisor");
        chk("prescale", 32'h0000_0002, pre);
        rc(4'h2, 32'h0000_0000, "unmapped");
        chk("rresp", 32'h0000_0002, rr);
    endtask
    task t_switch;
        wr(4'h0, 32'h0000_0100);
        rc(4'h0, 32'h0000_0000, "locked");
        unlock();
        wr(4'h0, 32'h0000_0117);
        rc(4'h0, 32'h0000_0101, "switching");
        repeat (10) @(posedge sys_clk);
        rc(4'h0, 32'h0000_1100, "switched");
        chk("active_osc", 32'h0000_0001, act_osc);
        rc(4'hC, 32'h0000_0002, "sw_status");
        chk("irq_masked", 32'h0000_0000, irq);
        wr(4'hC, 32'h0000_0200);
        unlock();
        wr(4'h0, 32'h0000_0001);
        repeat (10) @(posedge sys_clk);
        chk("irq", 32'h0000_0001, irq);
        chk("active_rc", 32'h0000_0000, act_osc);
        rc(4'hC, 32'h0000_0202, "sw_status2");
        chk("irq_clear", 32'h0000_0000, irq);
        wr(4'h0, 32'h0000_0100);
        rc(4'h0, 32'h0000_0000, "relocked");
    endtask
    task t_fail;
        t0 = traps;
        unlock();
        wr(4'h0, 32'h0000_0008);
        rc(4'h0, 32'h0000_0008, "fail_sw");
        chk("trap_sw", t0 + 1, traps);
        unlock();
        wr(4'h0, 32'h0000_0000);
        rc(4'h0, 32'h0000_0000, "fail_clr");
        @(posedge sys_clk);
        fail_det <= 1;
        repeat (3) @(posedge sys_clk);
        fail_det <= 0;
        rc(4'h0, 32'h0000_0008, "fail_hw");
        chk("trap_hw", t0 + 2, traps);
        unlock();
        wr(4'h0, 32'h0000_0000);
    endtask
    task t_slow;
        for (int i = 0; i < 32; i++)
        begin
            wr(4'h4, 32'(i));
            chk("prescale", 32'(i + 2), pre);
        end
        wr(4'h4, 32'h0000_0800);
        rc(4'h4, 32'h0000_0000, "apply_zero");
        wr(4'h4, 32'h0000_B800);
        rc(4'h4, 32'h0000_B800, "apply_set");
        wr(4'h4, 32'h0000_D800);
        rc(4'h4, 32'h0000_B800, "ratio_kept");
        chk("ratio", 32'h0000_0003, slow_ratio);
        @(posedge sys_clk);
        int_ev <= 1;
        @(posedge sys_clk);
        int_ev <= 0;
        rc(4'h4, 32'h0000_B000, "recovered");
        chk("apply_out", 32'h0000_0000, slow_act);
        wstrb <= 4'h1;
        wr(4'h4, 32'h0000_D805);
        rc(4'h4, 32'h0000_B005, "lane0_only");
        chk("prescale_lane", 32'h0000_0007, pre);
        wstrb <= 4'hF;
    endtask
    task test_done;
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        {rst_n, awvalid, wvalid, bready, arvalid, rready, fail_det, int_ev} = 8'h00;
        awaddr = 4'h0;
        araddr = 4'h0;
        wstrb = 4'hF;
        wdata = 32'h0000_0000;
        repeat (12) @(posedge sys_clk);
        rst_n <= 1;
        t_reset();
        t_switch();
        t_fail();
        t_slow();
        test_done();
    end
endmodule // ocd_clock_ctrl_tb_top
`default_nettype wire
